// *** cie_exec_core.sv ***
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "cie_consts.svh"
module cie_exec_core (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire cie_pkg::cie_axi_req_t axiReq,
    output cie_pkg::cie_axi_rsp_t      axiRsp
);

    cie_pkg::cie_regs_t s;
    cie_pkg::cie_regs_t next_s;

    logic [6:0]  fAddr;
    logic        dBit;
    logic [7:0]  fVal;
    logic [7:0]  incSum;
    logic [7:0]  orFile;
    logic [7:0]  orLit;
    logic [12:0] branchTarget;
    logic        execSkip;
    logic        execInc;
    logic        execOrFile;
    logic        execMove;
    logic        execOrLit;
    logic        execBranch;

    // True when an 8-bit result is zero.
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == 8'h00);
    endfunction

    // Merge write data into an old word under byte strobes.
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        mergeStrb = r;
    endfunction

    // Operand fields and results of the instruction under execution.
    assign fAddr        = s.instr[6:0];
    assign dBit         = s.instr[7];
    assign fVal         = s.file[fAddr];
    assign incSum       = fVal + 8'h01;
    assign orFile       = s.accum | fVal;
    assign orLit        = s.accum | s.instr[7:0];
    assign branchTarget = {s.latch[4:3], s.instr[10:0]};
    assign execSkip     = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:8] == `CIE_OP_INC_SKIP);
    assign execInc      = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:8] == `CIE_OP_INC);
    assign execOrFile   = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:8] == `CIE_OP_OR_FILE);
    assign execMove     = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:8] == `CIE_OP_MOVE);
    assign execOrLit    = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:8] == `CIE_OP_OR_LIT);
    assign execBranch   = (s.state == cie_pkg::CIE_EXEC) && (s.instr[13:11] == `CIE_OP_BRANCH);

    // Ready signals come from state only, so they never loop back to valid.
    always_comb begin
        axiRsp.awready = !s.awHeld;
        axiRsp.wready  = !s.wHeld;
        axiRsp.bvalid  = s.bvalid;
        axiRsp.bresp   = s.bresp;
        axiRsp.arready = !s.rvalid;
        axiRsp.rvalid  = s.rvalid;
        axiRsp.rdata   = s.rdata;
        axiRsp.rresp   = s.rresp;
    end

    // Bus slave and instruction execution in one next-state process.
    always_comb begin
        logic [31:0] wr;
        logic [11:0] ra;
        wr = 32'h0000_0000;
        ra = axiReq.araddr;
        next_s = s;
        if (axiReq.awvalid && !s.awHeld) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !s.wHeld) begin
            next_s.wHeld = 1'b1;
            next_s.wData = axiReq.wdata;
            next_s.wStrb = axiReq.wstrb;
        end
        if (s.bvalid && axiReq.bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && axiReq.rready) begin
            next_s.rvalid = 1'b0;
        end
        // Reads are served at any time, even while an instruction runs.
        if (axiReq.arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `CIE_RESP_OKAY;
            next_s.rdata  = 32'h0000_0000;
            if (ra[11:9] == `CIE_FILE_SEL) begin
                next_s.rdata[7:0] = s.file[ra[8:2]];
            end else begin
                case ({ra[11:2], 2'b00})
                    `CIE_OFF_INSTR:  next_s.rdata[13:0] = s.instr;
                    `CIE_OFF_ACCUM:  next_s.rdata[7:0] = s.accum;
                    `CIE_OFF_STATUS: begin
                        next_s.rdata[`CIE_STAT_ZERO] = s.zero;
                        next_s.rdata[`CIE_STAT_BUSY] = (s.state != cie_pkg::CIE_IDLE);
                    end
                    `CIE_OFF_PC:     next_s.rdata[12:0] = s.pc;
                    `CIE_OFF_LATCH:  next_s.rdata[4:0] = s.latch;
                    default:         next_s.rresp = `CIE_RESP_SLVERR;
                endcase
            end
        end
        case (s.state)
            cie_pkg::CIE_IDLE: begin
                // A write commits only once its previous response is gone.
                if (s.awHeld && s.wHeld && !s.bvalid) begin
                    next_s.awHeld = 1'b0;
                    next_s.wHeld  = 1'b0;
                    next_s.bresp  = `CIE_RESP_OKAY;
                    next_s.bvalid = 1'b1;
                    if (s.awAddr[11:9] == `CIE_FILE_SEL) begin
                        wr = mergeStrb({24'h000000, s.file[s.awAddr[8:2]]}, s.wData, s.wStrb);
                        next_s.file[s.awAddr[8:2]] = wr[7:0];
                    end else begin
                        case ({s.awAddr[11:2], 2'b00})
                            `CIE_OFF_INSTR: begin
                                wr = mergeStrb({18'h00000, s.instr}, s.wData, s.wStrb);
                                next_s.instr  = wr[13:0];
                                next_s.bvalid = 1'b0;
                                next_s.state  = cie_pkg::CIE_EXEC;
                            end
                            `CIE_OFF_ACCUM: begin
                                wr = mergeStrb({24'h000000, s.accum}, s.wData, s.wStrb);
                                next_s.accum = wr[7:0];
                            end
                            `CIE_OFF_STATUS: begin
                                wr = mergeStrb({31'h00000000, s.zero}, s.wData, s.wStrb);
                                next_s.zero = wr[`CIE_STAT_ZERO];
                            end
                            `CIE_OFF_PC: begin
                                wr = mergeStrb({19'h00000, s.pc}, s.wData, s.wStrb);
                                next_s.pc = wr[12:0];
                            end
                            `CIE_OFF_LATCH: begin
                                wr = mergeStrb({27'h0000000, s.latch}, s.wData, s.wStrb);
                                next_s.latch = wr[4:0];
                            end
                            default: next_s.bresp = `CIE_RESP_SLVERR;
                        endcase
                    end
                end
            end
            cie_pkg::CIE_EXEC: begin
                // Unknown encodings run as a no-operation of one cycle.
                next_s.pc     = s.pc + 13'h0001;
                next_s.state  = cie_pkg::CIE_IDLE;
                next_s.bvalid = 1'b1;
                if (execSkip) begin
                    if (dBit) next_s.file[fAddr] = incSum;
                    else next_s.accum = incSum;
                    if (isZero(incSum)) begin
                        // The following slot is spent as a no-operation.
                        next_s.pc     = s.pc + 13'h0002;
                        next_s.state  = cie_pkg::CIE_FLUSH;
                        next_s.bvalid = 1'b0;
                    end
                end else if (execInc) begin
                    if (dBit) next_s.file[fAddr] = incSum;
                    else next_s.accum = incSum;
                    next_s.zero = isZero(incSum);
                end else if (execOrFile) begin
                    if (dBit) next_s.file[fAddr] = orFile;
                    else next_s.accum = orFile;
                    next_s.zero = isZero(orFile);
                end else if (execMove) begin
                    // Writing back onto itself leaves the data as it was.
                    if (!dBit) next_s.accum = fVal;
                    next_s.zero = isZero(fVal);
                end else if (execOrLit) begin
                    next_s.accum = orLit;
                    next_s.zero  = isZero(orLit);
                end else if (execBranch) begin
                    next_s.pc     = branchTarget;
                    next_s.state  = cie_pkg::CIE_FLUSH;
                    next_s.bvalid = 1'b0;
                end
            end
            cie_pkg::CIE_FLUSH: begin
                // The discarded slot ends here; the write is answered now.
                next_s.state  = cie_pkg::CIE_IDLE;
                next_s.bvalid = 1'b1;
            end
            default: next_s.state = cie_pkg::CIE_IDLE;
        endcase
    end

    // State register; reset loads constants only.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s       <= '0;
            s.accum <= `CIE_ACCUM_RST;
            s.pc    <= `CIE_PC_RST;
            s.latch <= `CIE_LATCH_RST;
            s.zero  <= `CIE_ZERO_RST;
            s.state <= cie_pkg::CIE_IDLE;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence skipTaken;
        execSkip && isZero(incSum);
    endsequence

    sequence flushThenAnswer;
        (s.state == cie_pkg::CIE_FLUSH) && !s.bvalid ##1 (s.state == cie_pkg::CIE_IDLE) && s.bvalid;
    endsequence

    a_skip_two_cycle: assert property (skipTaken |=> flushThenAnswer)
        else $error("skip did not take two cycles");
    a_skip_pc_step: assert property (skipTaken |=> s.pc == $past(s.pc) + 13'h0002)
        else $error("skip did not pass over the next word");
    a_skip_flags_kept: assert property (execSkip |=> s.zero == $past(s.zero))
        else $error("skip increment changed the zero flag");
    a_skip_dest_file: assert property (execSkip && dBit |=> s.file[$past(fAddr)] == $past(incSum))
        else $error("skip increment sum not written to the register");
    a_move_zero_test: assert property (execMove |=> s.zero == isZero($past(fVal)))
        else $error("move did not test the value for zero");
    a_move_self_kept: assert property (execMove && dBit |=> (s.file[$past(fAddr)] == $past(fVal)) && (s.accum == $past(s.accum)))
        else $error("move onto itself altered data");
    a_branch_target: assert property (execBranch |=> s.pc == $past(branchTarget))
        else $error("branch loaded a wrong counter value");
    a_branch_two_cycle: assert property (execBranch |=> (s.zero == $past(s.zero)) ##0 flushThenAnswer)
        else $error("branch timing or flags wrong");
    a_or_lit_result: assert property (execOrLit |=> (s.accum == $past(orLit)) && (s.zero == isZero(s.accum)))
        else $error("literal OR result or zero flag wrong");
    a_inc_to_accum: assert property (execInc && !dBit |=> (s.accum == $past(incSum)) && (s.zero == isZero(s.accum)))
        else $error("increment to accumulator wrong");
    a_or_file_zero: assert property (execOrFile |=> s.zero == isZero($past(orFile)))
        else $error("file OR zero flag wrong");
    a_single_cycle: assert property ((execInc || execOrFile || execMove || execOrLit) |=> (s.state == cie_pkg::CIE_IDLE) && s.bvalid && (s.pc == $past(s.pc) + 13'h0001))
        else $error("single-cycle operation took longer");

endmodule

// *** cie_consts.svh ***
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH

// Register byte offsets on the AXI4-Lite port.
`define CIE_OFF_INSTR     12'h000
`define CIE_OFF_ACCUM     12'h004
`define CIE_OFF_STATUS    12'h008
`define CIE_OFF_PC        12'h00c
`define CIE_OFF_LATCH     12'h010
// The file array occupies 0x200..0x3fc, one byte per word.
`define CIE_FILE_SEL      3'h1

// Status field positions.
`define CIE_STAT_ZERO     0
`define CIE_STAT_BUSY     1

// Reset values.
`define CIE_ACCUM_RST     8'h00
`define CIE_PC_RST        13'h0000
`define CIE_LATCH_RST     5'h00
`define CIE_ZERO_RST      1'b0

// Instruction encodings (top opcode bits of the 14-bit word).
`define CIE_OP_INC_SKIP   6'h0f
`define CIE_OP_INC        6'h0a
`define CIE_OP_OR_FILE    6'h04
`define CIE_OP_MOVE       6'h08
`define CIE_OP_OR_LIT     6'h38
`define CIE_OP_BRANCH     3'h5

// AXI response codes.
`define CIE_RESP_OKAY     2'h0
`define CIE_RESP_SLVERR   2'h2

`endif

// *** cie_pkg.sv ***
package cie_pkg;

    typedef enum logic [1:0] {
        CIE_IDLE,
        CIE_EXEC,
        CIE_FLUSH
    } cie_state_t;

    // Master-to-slave AXI4-Lite signals.
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } cie_axi_req_t;

    // Slave-to-master AXI4-Lite signals.
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cie_axi_rsp_t;

    // Whole state of the execution core.
    typedef struct packed {
        cie_state_t       state;
        logic             awHeld;
        logic [11:0]      awAddr;
        logic             wHeld;
        logic [31:0]      wData;
        logic [3:0]       wStrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic [13:0]      instr;
        logic [7:0]       accum;
        logic             zero;
        logic [12:0]      pc;
        logic [4:0]       latch;
        logic [127:0][7:0] file;
    } cie_regs_t;

endpackage

// *** cie_prog_mem.sv ***
`timescale 1ns/100ps
// Program store on the far side; a word is read back at once by its address.
module cie_prog_mem (
    input  wire logic [12:0] fetchAddr,
    output logic      [13:0] fetchWord
);
    logic [13:0] words [0:8191];

    // Empty words hold zero, which the core runs as a no-operation.
    initial begin
        for (int i = 0; i < 8192; i++) words[i] = 14'h0000;
    end
    assign fetchWord = words[fetchAddr];
endmodule

// *** core_inc_or_move_branch_exec_test.sv ***
`timescale 1ns/100ps
`include "cie_consts.svh"
module core_inc_or_move_branch_exec_test;
    localparam logic [11:0] A_ACC = `CIE_OFF_ACCUM;
    localparam logic [11:0] A_ST  = `CIE_OFF_STATUS;
    localparam logic [11:0] A_PC  = `CIE_OFF_PC;
    logic                  ref_clk = 1'b0;
    logic                  rst_b   = 1'b0;
    cie_pkg::cie_axi_req_t axiReq  = '0;
    cie_pkg::cie_axi_rsp_t axiRsp;
    logic [12:0]           fetchPc = 13'h0000;
    logic [13:0]           fetchWord;
    logic [31:0]           rdData;
    logic [1:0]            lastResp;
    int                    lastCyc, cycOne, skipCyc, cycles, numErrors, comparisons;

    // Clock at 40 MHz.
    always #12.5 ref_clk = ~ref_clk;

    cie_exec_core dut_u (
        .ref_clk(ref_clk),
        .rst_b  (rst_b),
        .axiReq (axiReq),
        .axiRsp (axiRsp)
    );
    cie_prog_mem prog_u (
        .fetchAddr(fetchPc),
        .fetchWord(fetchWord)
    );

    // Hang guard; the whole run needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (numErrors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Address and data go out together; bready stays up until the answer is seen.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr  <= a;
        axiReq.wvalid  <= 1'b1;
        axiReq.wdata   <= d;
        axiReq.wstrb   <= 4'hf;
        axiReq.bready  <= 1'b1;
        lastCyc = 0;
        do begin
            @(posedge ref_clk);
            lastCyc++;
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (axiRsp.bvalid !== 1'b1);
        axiReq.bready <= 1'b0;
        lastResp = axiRsp.bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge ref_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr  <= a;
        axiReq.rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (axiRsp.rvalid !== 1'b1);
        axiReq.rready <= 1'b0;
        rdData   = axiRsp.rdata;
        lastResp = axiRsp.rresp;
    endtask

    task automatic chk(input string n, input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        check(n, rdData, exp);
    endtask

    function automatic logic [11:0] fa(input logic [6:0] f);
        return 12'h200 + {3'h0, f, 2'h0};
    endfunction

    function automatic logic [31:0] fop(input logic [5:0] op, input logic d, input logic [6:0] f);
        return {18'h00000, op, d, f};
    endfunction

    task automatic exec(input logic [31:0] w);
        wr(`CIE_OFF_INSTR, w);
    endtask

    // Fetch the word at the current counter; the short delay keeps the fetch off the edge.
    task automatic step();
        rd(A_PC);
        fetchPc = rdData[12:0];
        #1;
        exec({18'h00000, fetchWord});
    endtask

    task automatic t_reset();
        chk("pc", A_PC, 32'h0);
        rd(12'h100);
        check("bad resp", {30'h0, lastResp}, {30'h0, `CIE_RESP_SLVERR});
        check("bad data", rdData, 32'h0);
        wr(12'h100, 32'h5);
        check("bad wresp", {30'h0, lastResp}, {30'h0, `CIE_RESP_SLVERR});
        wr(`CIE_OFF_LATCH, 32'h0);
        check("wresp", {30'h0, lastResp}, {30'h0, `CIE_RESP_OKAY});
    endtask

    // Zero sum skips the or-literal word that follows; a second skip word runs next.
    task automatic t_skip();
        wr(A_PC, 32'h10);
        wr(fa(7'h05), 32'hff);
        wr(A_ACC, 32'h11);
        wr(A_ST, 32'h0);
        prog_u.words[16] = {`CIE_OP_INC_SKIP, 1'b1, 7'h05};
        prog_u.words[17] = {`CIE_OP_OR_LIT, 8'hff};
        prog_u.words[18] = {`CIE_OP_INC_SKIP, 1'b0, 7'h05};
        step();
        skipCyc = lastCyc;
        chk("file", fa(7'h05), 32'h0);
        chk("pc", A_PC, 32'h12);
        chk("acc", A_ACC, 32'h11);
        chk("zero", A_ST, 32'h0);
        wr(A_ST, 32'h1);
        step();
        cycOne = lastCyc;
        check("cycles", skipCyc - cycOne, 32'h1);
        chk("acc", A_ACC, 32'h1);
        chk("pc", A_PC, 32'h13);
        chk("zero", A_ST, 32'h1);
    endtask

    task automatic t_inc();
        wr(fa(7'h09), 32'hff);
        exec(fop(`CIE_OP_INC, 1'b0, 7'h09));
        check("cycles", lastCyc, cycOne);
        chk("acc", A_ACC, 32'h0);
        chk("zero", A_ST, 32'h1);
        chk("file", fa(7'h09), 32'hff);
        wr(fa(7'h09), 32'h7f);
        exec(fop(`CIE_OP_INC, 1'b1, 7'h09));
        chk("file", fa(7'h09), 32'h80);
        chk("zero", A_ST, 32'h0);
        chk("acc", A_ACC, 32'h0);
    endtask

    task automatic t_or();
        wr(A_ACC, 32'h0);
        exec({18'h0, `CIE_OP_OR_LIT, 8'h00});
        chk("zero", A_ST, 32'h1);
        // A non-zero accumulator tells an OR apart from a sum; 0x81 sets no bit outside 0xa5, so not from a plain load.
        wr(A_ACC, 32'h81);
        exec({18'h0, `CIE_OP_OR_LIT, 8'ha5});
        check("cycles", lastCyc, cycOne);
        chk("acc", A_ACC, 32'ha5);
        chk("zero", A_ST, 32'h0);
        wr(fa(7'h7f), 32'h5f);
        exec(fop(`CIE_OP_OR_FILE, 1'b1, 7'h7f));
        chk("file", fa(7'h7f), 32'hff);
        chk("acc", A_ACC, 32'ha5);
        wr(fa(7'h7f), 32'h0);
        wr(A_ACC, 32'h0);
        exec(fop(`CIE_OP_OR_FILE, 1'b0, 7'h7f));
        chk("zero", A_ST, 32'h1);
    endtask

    task automatic t_move();
        wr(A_ACC, 32'h33);
        wr(fa(7'h03), 32'h0);
        exec(fop(`CIE_OP_MOVE, 1'b1, 7'h03));
        check("cycles", lastCyc, cycOne);
        chk("zero", A_ST, 32'h1);
        chk("file", fa(7'h03), 32'h0);
        chk("acc", A_ACC, 32'h33);
        wr(fa(7'h40), 32'h80);
        exec(fop(`CIE_OP_MOVE, 1'b0, 7'h40));
        chk("acc", A_ACC, 32'h80);
        chk("zero", A_ST, 32'h0);
    endtask

    // Both latch bit values of the upper counter bits are tried.
    task automatic t_branch();
        wr(A_ST, 32'h1);
        wr(`CIE_OFF_LATCH, 32'h18);
        exec({18'h0, `CIE_OP_BRANCH, 11'h7ff});
        check("cycles", lastCyc, cycOne + 1);
        chk("pc", A_PC, 32'h1fff);
        chk("zero", A_ST, 32'h1);
        wr(A_ST, 32'h0);
        wr(`CIE_OFF_LATCH, 32'h07);
        exec({18'h0, `CIE_OP_BRANCH, 11'h400});
        chk("pc", A_PC, 32'h0400);
        chk("zero", A_ST, 32'h0);
    endtask

    // Reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_skip();
        t_inc();
        t_or();
        t_move();
        t_branch();
        stop_test();
    end
endmodule
